/* File: hdl/srcs_sequencer.sv */
// Purpose: Reset and bus clock sequencer with a Wishbone register slave.
// Assumes: One reference clock; pad input synchronous after two flops.
// Notes:   Clock outputs are flop-divided clocks, some gated by logic; CLOCKGEN_OUTPUT_O can pass the PLL clock.
//
// Chosen here: register access over Wishbone and the register offsets.
`timescale 1ns/1ns
`include "srcs_defines.svh"

module srcs_sequencer #(
   parameter int STAB_CYCLES = 4096
) (
   // Clock and reset
   input  wire logic        CLK_I,
   input  wire logic        SYS_RST_I,
   // Wishbone slave
   input  wire logic        CYC_I,
   input  wire logic        STB_I,
   input  wire logic        WE_I,
   input  wire logic [3:0]  ADR_I,
   input  wire logic [3:0]  SEL_I,
   input  wire logic [31:0] DAT_I,
   output logic      [31:0] DAT_O,
   output logic             ACK_O,
   // Reset sources
   input  wire logic        POWER_ON_PULSE_I,
   input  wire logic        LOW_VOLTAGE_RESET_I,
   input  wire logic        WATCHDOG_TIMEOUT_I,
   input  wire logic        ILLEGAL_OPCODE_I,
   input  wire logic        STOP_OPCODE_I,
   input  wire logic        OPCODE_FETCH_I,
   input  wire logic        ADDR_UNMAPPED_I,
   // Clock sources
   input  wire logic        PLL_OUTPUT_CLOCK_I,
   // External reset pad
   input  wire logic        RST_PAD_N_I,
   output logic             RST_PAD_N_O,
   output logic             RST_PAD_OE_O,
   // System outputs
   output logic             INTERNAL_RESET_O,
   output logic             HALT_O,
   output logic [15:0]      RESET_VECTOR_O,
   output logic             CLOCKGEN_OUTPUT_O,
   output logic             BUS_CLOCK_O,
   output logic             CPU_CLOCK_O,
   output logic             PERIPH_CLOCK_A_O,
   output logic             PERIPH_CLOCK_B_O,
   output logic             WATCHDOG_CLOCK_O
);

   // ==========================================================
   // Declarations
   srcs_pkg::srcs_state_t state_q, state_d;
   logic [12:0] cnt_q, cnt_d;
   logic [12:0] presc_q;
   logic [12:0] pin_cnt_q;
   logic [5:0]  cause_q;
   logic [2:0]  ctrl_q;
   logic        pad_s1_q, pad_s2_q;
   logic        wdt_s1_q, wdt_s2_q;
   logic        por_seen_q;
   logic        cgm_en_q;
   logic        div_q;
   logic [1:0]  bus_div_q;
   logic        ack_q;
   logic [31:0] dat_q;
   logic        wdt_ovf_q;

   localparam logic [12:0] STAB_N = STAB_CYCLES[12:0];
   localparam logic [12:0] PIN_POR_N = STAB_N + 13'd67;

   // Source decode.
   wire pwr_evt   = POWER_ON_PULSE_I | LOW_VOLTAGE_RESET_I;
   wire illegal_address_flag_evt  = OPCODE_FETCH_I & ADDR_UNMAPPED_I;
   wire illegal_opcode_flag_evt  = ILLEGAL_OPCODE_I | STOP_OPCODE_I;
   wire wdt_evt   = wdt_s2_q;
   wire int_evt   = pwr_evt | illegal_address_flag_evt | illegal_opcode_flag_evt | wdt_evt;
   wire pad_low   = ~pad_s2_q;
   wire seq_rst   = (state_q != srcs_pkg::SRCS_RUN);
   wire in_rst    = seq_rst | pad_low;
   wire wb_req    = CYC_I & STB_I & ~ack_q;
   wire wr_ctrl   = wb_req & WE_I & SEL_I[0] & (ADR_I == `SRCS_CTRL_ADDR);
   wire [12:0] pin_thr = por_seen_q ? PIN_POR_N : 13'(`SRCS_PIN_MIN);

   // Count comparison helper.
   function automatic logic done(input logic [12:0] c, input logic [12:0] n);
      done = (c == n - 13'd1);
   endfunction

   // ==========================================================
   // Synchronisers for the pad and the watchdog request.
   // Only the second flop of each pair is read, so a metastable first flop stays contained.
   always_ff @(posedge CLK_I) begin
      pad_s1_q <= SYS_RST_I ? 1'b1 : RST_PAD_N_I;
      pad_s2_q <= SYS_RST_I ? 1'b1 : pad_s1_q;
      wdt_s1_q <= SYS_RST_I ? 1'b0 : WATCHDOG_TIMEOUT_I;
      wdt_s2_q <= SYS_RST_I ? 1'b0 : wdt_s1_q;
   end

   // ==========================================================
   // Sequencer next state.
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q + 13'd1;
      unique case (state_q)
         srcs_pkg::SRCS_RUN: begin
            cnt_d = '0;
            if (pwr_evt) begin
               state_d = srcs_pkg::SRCS_STAB;
            end else if (int_evt) begin
               state_d = srcs_pkg::SRCS_DRIVE;
            end else if (pad_low) begin
               state_d = srcs_pkg::SRCS_PADIN;
            end
         end
         srcs_pkg::SRCS_STAB: begin
            if (pwr_evt) begin
               cnt_d = '0;
            end else if (done(cnt_q, STAB_N)) begin
               state_d = srcs_pkg::SRCS_DRIVE;
               cnt_d   = '0;
            end
         end
         srcs_pkg::SRCS_DRIVE: begin
            if (pwr_evt) begin
               state_d = srcs_pkg::SRCS_STAB;
               cnt_d   = '0;
            end else if (done(cnt_q, 13'(`SRCS_DRIVE_CYCLES))) begin
               state_d = srcs_pkg::SRCS_EXTEND;
               cnt_d   = '0;
            end
         end
         srcs_pkg::SRCS_EXTEND: begin
            if (pwr_evt) begin
               state_d = srcs_pkg::SRCS_STAB;
               cnt_d   = '0;
            end else if (done(cnt_q, 13'(`SRCS_EXT_CYCLES))) begin
               state_d = srcs_pkg::SRCS_RUN;
               cnt_d   = '0;
            end
         end
         srcs_pkg::SRCS_PADIN: begin
            cnt_d = '0;
            if (pwr_evt) begin
               state_d = srcs_pkg::SRCS_STAB;
            end else if (int_evt) begin
               state_d = srcs_pkg::SRCS_DRIVE;
            end else if (!pad_low) begin
               state_d = srcs_pkg::SRCS_EXTEND;
            end
         end
         default: begin
            state_d = srcs_pkg::SRCS_STAB;
            cnt_d   = '0;
         end
      endcase
   end

   // Sequencer state register; system reset acts as a power-on.
   // A repeated power event restarts the count, so the supply settles before release.
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         state_q <= srcs_pkg::SRCS_STAB;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // ==========================================================
   // Free-running prescaler, cleared by internal sources only.
   always_ff @(negedge CLK_I) begin
      if (SYS_RST_I || int_evt) begin
         presc_q   <= '0;
         wdt_ovf_q <= 1'b0;
      end else begin
         presc_q   <= presc_q + 13'd1;
         wdt_ovf_q <= (presc_q == 13'h1fff);
      end
   end

   // Pad-low duration counter.
   // It saturates rather than wraps, so a very long hold cannot reach the threshold again.
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I || !pad_low) begin
         pin_cnt_q <= '0;
      end else if (pin_cnt_q != 13'h1fff) begin
         pin_cnt_q <= pin_cnt_q + 13'd1;
      end
   end

   // ==========================================================
   // Cause flags; events set, power-on clears the others.
   // Flags are sticky: software cannot clear them, only a power-on pulse or the system reset does.
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         cause_q    <= 6'h20;
         por_seen_q <= 1'b1;
      end else begin
         if (POWER_ON_PULSE_I) begin
            cause_q <= 6'h20;
         end else begin
            if (LOW_VOLTAGE_RESET_I) cause_q[`SRCS_BIT_LVR] <= 1'b1;
            if (wdt_evt)  cause_q[`SRCS_BIT_WDT]  <= 1'b1;
            if (illegal_opcode_flag_evt) cause_q[`SRCS_BIT_ILLEGAL_OPCODE_FLAG] <= 1'b1;
            if (illegal_address_flag_evt) cause_q[`SRCS_BIT_ILLEGAL_ADDRESS_FLAG] <= 1'b1;
            if (pin_cnt_q == pin_thr - 13'd1) begin
               cause_q[`SRCS_BIT_PIN] <= 1'b1;
            end
         end
         if (pwr_evt) begin
            por_seen_q <= 1'b1;
         end else if (state_q == srcs_pkg::SRCS_RUN) begin
            por_seen_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Control register; internal reset returns it to default.
   // Writes made while reset is active are dropped on purpose.
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I || in_rst) begin
         ctrl_q <= 3'h0;
      end else if (wr_ctrl) begin
         ctrl_q <= DAT_I[2:0];
      end
   end

   // Clock output enable after power-on.
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         cgm_en_q <= 1'b0;
      end else begin
         cgm_en_q <= 1'b1;
      end
   end

   // ==========================================================
   // Bus clock dividers: output halved, bus at a quarter.
   // Holding both dividers at zero parks the bus, CPU and peripheral A clocks low; peripheral B is held low by the seq_rst gate.
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I || seq_rst) begin
         div_q     <= 1'b0;
         bus_div_q <= 2'b00;
      end else begin
         div_q     <= ~div_q;
         bus_div_q <= bus_div_q + 2'd1;
      end
   end

   // Clock output follows the selected source while enabled.
   wire src_clk = ctrl_q[`SRCS_BIT_PLLSEL] ? PLL_OUTPUT_CLOCK_I : div_q;
   assign CLOCKGEN_OUTPUT_O = cgm_en_q & src_clk;
   assign BUS_CLOCK_O       = bus_div_q[1];
   assign CPU_CLOCK_O       = bus_div_q[1] & ~ctrl_q[`SRCS_BIT_WAIT];
   assign PERIPH_CLOCK_A_O  = bus_div_q[1];
   assign PERIPH_CLOCK_B_O  = ~bus_div_q[1] & ~seq_rst;
   assign WATCHDOG_CLOCK_O  = wdt_ovf_q;

   // ==========================================================
   // Pad drive, internal reset, halt and vector.
   // The pad is only ever pulled low; release leaves it to the board pull-up.
   wire drive_pad = (state_q == srcs_pkg::SRCS_STAB) | (state_q == srcs_pkg::SRCS_DRIVE);
   assign RST_PAD_N_O      = 1'b0;
   assign RST_PAD_OE_O     = drive_pad;
   assign INTERNAL_RESET_O = in_rst;
   assign HALT_O           = in_rst;
   assign RESET_VECTOR_O   = ctrl_q[`SRCS_BIT_MONITOR] ? `SRCS_VEC_MON : `SRCS_VEC_USER;

   // ==========================================================
   // Wishbone slave: one-cycle ack, unmapped reads zero.
   // Ack drops for one cycle after each answer, so a held request is answered every second cycle.
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         ack_q <= 1'b0;
         dat_q <= '0;
      end else begin
         ack_q <= wb_req;
         unique case (ADR_I)
            `SRCS_CAUSE_ADDR: dat_q <= {26'h0, cause_q};
            `SRCS_CTRL_ADDR:  dat_q <= {29'h0, ctrl_q};
            `SRCS_STAT_ADDR:  dat_q <= {28'h0, por_seen_q, state_q};
            default:          dat_q <= '0;
         endcase
      end
   end
   assign ACK_O = ack_q;
   assign DAT_O = dat_q;

   // ==========================================================
   // Checks.
   property p_drive_len;
      @(posedge CLK_I) disable iff (SYS_RST_I)
      $rose(state_q == srcs_pkg::SRCS_DRIVE) && !pwr_evt |->
         (RST_PAD_OE_O || pwr_evt) [*8];
   endproperty
   a_drive_len: assert property (p_drive_len) else $error("pad drive too short");

   property p_extend;
      @(posedge CLK_I) disable iff (SYS_RST_I)
      $fell(RST_PAD_OE_O) && state_q == srcs_pkg::SRCS_EXTEND |-> INTERNAL_RESET_O [*8];
   endproperty
   a_extend: assert property (p_extend) else $error("reset extension short");

   property p_stab_pad;
      @(posedge CLK_I) disable iff (SYS_RST_I)
      state_q == srcs_pkg::SRCS_STAB |-> RST_PAD_OE_O && !RST_PAD_N_O;
   endproperty
   a_stab_pad: assert property (p_stab_pad) else $error("pad not driven in count");

   property p_stab_clk;
      @(posedge CLK_I) disable iff (SYS_RST_I)
      state_q == srcs_pkg::SRCS_STAB |=> !BUS_CLOCK_O;
   endproperty
   a_stab_clk: assert property (p_stab_clk) else $error("bus clock during count");

   property p_wait;
      @(posedge CLK_I) disable iff (SYS_RST_I)
      ctrl_q[`SRCS_BIT_WAIT] && !in_rst && !wr_ctrl |=>
         !CPU_CLOCK_O && (bus_div_q != $past(bus_div_q));
   endproperty
   a_wait: assert property (p_wait) else $error("cpu clock in wait");

   property p_illegal_opcode_flag;
      @(posedge CLK_I) disable iff (SYS_RST_I)
      illegal_opcode_flag_evt && !POWER_ON_PULSE_I |=> cause_q[`SRCS_BIT_ILLEGAL_OPCODE_FLAG] ##1 INTERNAL_RESET_O;
   endproperty
   a_illegal_opcode_flag: assert property (p_illegal_opcode_flag) else $error("illegal opcode not handled");

   property p_por;
      @(posedge CLK_I) disable iff (SYS_RST_I)
      POWER_ON_PULSE_I |=> cause_q == 6'h20;
   endproperty
   a_por: assert property (p_por) else $error("power-on cause wrong");

   property p_data_fetch;
      @(posedge CLK_I) disable iff (SYS_RST_I)
      ADDR_UNMAPPED_I && !OPCODE_FETCH_I && !int_evt && !pad_low
         && state_q == srcs_pkg::SRCS_RUN |=> state_q == srcs_pkg::SRCS_RUN;
   endproperty
   a_data_fetch: assert property (p_data_fetch) else $error("data fetch reset");

   property p_presc;
      @(posedge CLK_I) disable iff (SYS_RST_I)
      int_evt |-> presc_q == 13'h0 && !wdt_ovf_q;
   endproperty
   a_presc: assert property (p_presc) else $error("prescaler kept");

endmodule

/* File: hdl/srcs_defines.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the reset sequencer.
// Assumes: Reference clock of 20 MHz, one word per register on the bus.
// Notes:   Definitions only.
`ifndef SRCS_DEFINES_SVH
`define SRCS_DEFINES_SVH
// ==========================================================
// Register offsets (byte addresses)
`define SRCS_CAUSE_ADDR    4'h0
`define SRCS_CTRL_ADDR     4'h4
`define SRCS_STAT_ADDR     4'h8
// ==========================================================
// Cause register fields
`define SRCS_BIT_POR       5
`define SRCS_BIT_PIN       4
`define SRCS_BIT_WDT       3
`define SRCS_BIT_ILLEGAL_OPCODE_FLAG      2
`define SRCS_BIT_ILLEGAL_ADDRESS_FLAG      1
`define SRCS_BIT_LVR       0
// Control register fields
`define SRCS_BIT_PLLSEL    0
`define SRCS_BIT_WAIT      1
`define SRCS_BIT_MONITOR   2
// ==========================================================
// Timing counts in reference clock cycles
`define SRCS_STAB_CYCLES   13'd4096
`define SRCS_DRIVE_CYCLES  7'd32
`define SRCS_EXT_CYCLES    7'd32
`define SRCS_POR_REL       7'd64
`define SRCS_PIN_MIN       7'd67
`define SRCS_PIN_MIN_POR   13'd4163
// Reset vectors
`define SRCS_VEC_USER      16'hfffe
`define SRCS_VEC_MON       16'hfefe
`endif

/* File: hdl/srcs_pkg.sv */
// Purpose: Types of the reset sequencer.
// Assumes: Nothing is imported.
// Notes:   State codes are Gray along the usual path.
package srcs_pkg;
   // ==========================================================
   // Sequencer states
   typedef enum logic [2:0] {
      SRCS_RUN    = 3'b000,
      SRCS_STAB   = 3'b001,
      SRCS_DRIVE  = 3'b011,
      SRCS_EXTEND = 3'b010,
      SRCS_PADIN  = 3'b110
   } srcs_state_t;
endpackage

/* File: tb/srcs_pad_model.sv */
// Purpose: External reset circuitry sharing the reset pad with the sequencer.
// Assumes: The pad has a pull-up, so a released pad reads high.
// Notes:   Pulls the pad low only while the bench asks for it.
`timescale 1ns/1ns
module srcs_pad_model (
   // Sequencer pad driver
   input  wire logic pad_n_i,
   input  wire logic pad_oe_i,
   // Bench request to pull the pad low
   input  wire logic pull_low_i,
   // Resolved pad level
   output logic      pad_level_o
);
   // Wired-AND of both drivers over the pull-up.
   assign pad_level_o = (pad_oe_i ? pad_n_i : 1'b1) & ~pull_low_i;
endmodule

/* File: tb/srcs_tb.sv */
// Purpose: Self-checking bench of the reset and bus clock sequencer.
// Assumes: Stabilisation count shortened to 64 cycles.
// Notes:   Registers are reached over classic Wishbone.
`timescale 1ns/1ns
`include "srcs_defines.svh"
module system_reset_clock_sequencer_tb_top;
   localparam int STAB = 64;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, pull = 1'b0;
   logic wdt = 1'b0, illegal_opcode_flag = 1'b0, stp = 1'b0, fetch = 1'b0, unmap = 1'b0, lvr = 1'b0;
   logic por = 1'b0, pll = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] dat_w = 32'h0, dat_r, rd;
   logic ack, pad, pad_o, pad_oe, internal_reset, halt, busclk, cpuclk, pca, pcb, cgo, wdclk;
   logic [15:0] vec;
   int err_count = 0, check_count = 0, n;

   // ==========================================================
   // Clock, pad model and design
   initial forever #25 clk = ~clk;

   srcs_pad_model u_pad (.pad_n_i(pad_o), .pad_oe_i(pad_oe), .pull_low_i(pull),
                         .pad_level_o(pad));

   srcs_sequencer #(.STAB_CYCLES(STAB)) DUT (
      .CLK_I(clk), .SYS_RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
      .ADR_I(adr), .SEL_I(4'hf), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
      .POWER_ON_PULSE_I(por), .LOW_VOLTAGE_RESET_I(lvr), .WATCHDOG_TIMEOUT_I(wdt),
      .ILLEGAL_OPCODE_I(illegal_opcode_flag), .STOP_OPCODE_I(stp), .OPCODE_FETCH_I(fetch),
      .ADDR_UNMAPPED_I(unmap), .PLL_OUTPUT_CLOCK_I(pll), .RST_PAD_N_I(pad),
      .RST_PAD_N_O(pad_o), .RST_PAD_OE_O(pad_oe), .INTERNAL_RESET_O(internal_reset),
      .HALT_O(halt), .RESET_VECTOR_O(vec), .CLOCKGEN_OUTPUT_O(cgo), .BUS_CLOCK_O(busclk),
      .CPU_CLOCK_O(cpuclk), .PERIPH_CLOCK_A_O(pca), .PERIPH_CLOCK_B_O(pcb),
      .WATCHDOG_CLOCK_O(wdclk));

   // ==========================================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic stop_test;
      if (err_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // One classic cycle; holds the request until ack is sampled high.
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1);
      rd = dat_r;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge clk);
      check(n, 2); // Ack stands one cycle after the take.
   endtask

   // Waits for the pad drive, counts its length and flags a high pad.
   task automatic pulse_len(output int len, output int bad);
      n = 0;
      bad = 0;
      while (pad_oe !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      len = 0;
      while (pad_oe === 1'b1 && len < 300) begin
         bad |= (pad !== 1'b0) | (halt !== 1'b1);
         @(posedge clk);
         len++;
      end
   endtask

   // Counts how long the internal reset outlives the pad drive.
   task automatic ext_len(output int len);
      len = 0;
      while (internal_reset === 1'b1 && len < 300) begin
         @(posedge clk);
         len++;
      end
   endtask

   // Counts level changes of bus, CPU and peripheral A clocks over 16 cycles.
   task automatic toggles(output int c0, output int c1, output int c2);
      logic pb, pc, pp;
      c0 = 0; c1 = 0; c2 = 0; pb = busclk; pc = cpuclk; pp = pca;
      repeat (16) begin
         @(posedge clk);
         c0 += (busclk !== pb); c1 += (cpuclk !== pc); c2 += (pca !== pp);
         pb = busclk; pc = cpuclk; pp = pca;
      end
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_power_on;
      int len, bad;
      pulse_len(len, bad);
      check(len >= STAB + 30 && len <= STAB + 34, 1'b1);
      check(bad, 0);
      ext_len(len);
      check(len >= 32 && len <= 36, 1'b1);
      wb(1'b0, `SRCS_CAUSE_ADDR, 32'h0);
      check(rd, 32'h20);
      check(vec, `SRCS_VEC_USER);
   endtask

   task automatic t_internal;
      int len, bad, k;
      int bits[5] = '{3, 2, 2, 1, 0};
      logic [31:0] exp = 32'h20;
      for (k = 0; k < 5; k++) begin
         wdt <= (k == 0); illegal_opcode_flag <= (k == 1); stp <= (k == 2);
         fetch <= (k == 3); unmap <= (k == 3); lvr <= (k == 4);
         @(posedge clk);
         {wdt, illegal_opcode_flag, stp, fetch, unmap, lvr} <= 6'h0;
         pulse_len(len, bad);
         check(len, k == 4 ? STAB + 32 : 32);
         check(bad, 0);
         ext_len(len);
         check(len >= 32 && len <= 36, 1'b1);
         wb(1'b0, `SRCS_CAUSE_ADDR, 32'h0);
         check(rd[bits[k]], 1'b1);
         exp[bits[k]] = 1'b1;
         check(rd, exp);
      end
   endtask

   // An unmapped data fetch must not start any reset.
   task automatic t_data_fetch;
      int bad;
      bad = 0;
      unmap <= 1'b1;
      repeat (40) begin
         @(posedge clk);
         bad |= (pad_oe !== 1'b0) | (internal_reset !== 1'b0);
      end
      unmap <= 1'b0;
      check(bad, 0);
   endtask

   task automatic t_pad(input int low, input logic exp);
      int len;
      pull <= 1'b1;
      repeat (low) @(posedge clk);
      check(halt, 1'b1);
      check(pad_oe, 1'b0);
      pull <= 1'b0;
      @(posedge clk);
      ext_len(len);
      wb(1'b0, `SRCS_CAUSE_ADDR, 32'h0);
      check(rd[`SRCS_BIT_PIN], exp);
   endtask

   task automatic t_ctrl;
      int c0, c1, c2;
      c0 = cgo;
      @(posedge clk);
      check(cgo !== c0[0], 1'b1);
      toggles(c0, c1, c2);
      check(c0, 8);
      check(c1, 8);
      wb(1'b1, `SRCS_CTRL_ADDR, 32'h6);
      check(vec, `SRCS_VEC_MON);
      toggles(c0, c1, c2);
      check(c1, 0);
      check(c2 != 0, 1'b1);
      check(pcb ^ pca, 1'b1);
      wb(1'b0, `SRCS_CTRL_ADDR, 32'h0);
      check(rd, 32'h6);
      wb(1'b0, 4'hc, 32'h0);
      check(rd, 32'h0);
      wb(1'b1, `SRCS_CTRL_ADDR, 32'h0);
      check(vec, `SRCS_VEC_USER);
      wb(1'b1, `SRCS_CTRL_ADDR, 32'h1);
      pll <= 1'b1;
      @(posedge clk);
      check(cgo, 1'b1);
      pll <= 1'b0;
      @(posedge clk);
      check(cgo, 1'b0);
   endtask

   // Overflow comes 8192 cycles after an internal clear; a pad reset does not restart it.
   task automatic t_presc;
      int len;
      illegal_opcode_flag <= 1'b1;
      @(posedge clk);
      illegal_opcode_flag <= 1'b0;
      repeat (200) @(posedge clk);
      pull <= 1'b1;
      repeat (80) @(posedge clk);
      pull <= 1'b0;
      len = 281;
      while (wdclk !== 1'b1 && len < 9000) begin
         @(posedge clk);
         len++;
      end
      check(len >= 8190 && len <= 8196, 1'b1); // and
      wb(1'b0, `SRCS_CTRL_ADDR, 32'h0);
      check(rd, 32'h0);
   endtask

   // A power-on pulse runs the long sequence and leaves only its own flag.
   task automatic t_por;
      int len, bad;
      por <= 1'b1;
      @(posedge clk);
      por <= 1'b0;
      pulse_len(len, bad);
      check(len, STAB + 32);
      check(bad, 0);
      ext_len(len);
      check(len >= 32 && len <= 36, 1'b1);
      wb(1'b0, `SRCS_CAUSE_ADDR, 32'h0);
      check(rd, 32'h20);
   endtask

   // ==========================================================
   // Main sequence and hang guard
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_power_on;
      t_internal;
      t_data_fetch;
      t_pad(20, 1'b0);
      t_pad(75, 1'b1);
      t_ctrl;
      t_presc;
      t_por;
      stop_test;
   end

   initial begin
      #1500000;
      err_count++;
      stop_test;
   end
endmodule
